// ### irqc_pkg.sv
// constants and types for the interrupt flag, enable and priority register block
`default_nettype none

package irqc_pkg;

  // ------------------------------------------------------------------
  // bus and register map
  // ------------------------------------------------------------------
  localparam int          ADDR_W        = 12;
  localparam int          DATA_W        = 32;
  localparam logic [3:0]  FLAG_REGION   = 4'h0;
  localparam logic [3:0]  ENABLE_REGION = 4'h1;
  localparam logic [3:0]  PRIO_REGION   = 4'h2;
  localparam logic [3:0]  EVT_REGION    = 4'h3;
  localparam logic [5:0]  EVT_STAT_IDX  = 6'h00;
  localparam logic [5:0]  EVT_MASK_IDX  = 6'h01;

  // ------------------------------------------------------------------
  // reset values and field layout
  // ------------------------------------------------------------------
  localparam logic [31:0] RESET_WORD     = 32'h0000_0000;
  localparam logic [31:0] PRIO_IMPL_MASK = 32'h1f1f_1f1f;
  localparam int          DEF_BANKS      = 2;
  localparam int          SRC_PER_BANK   = 32;
  localparam int          SLOTS_PER_REG  = 4;
  localparam int          SLOT_W         = 8;
  localparam int          PRIO_LSB       = 2;
  localparam int          PRIO_W         = 3;
  localparam int          SUB_LSB        = 0;
  localparam int          SUB_W          = 2;
  localparam logic [2:0]  PRIO_OFF       = 3'h0;

  // ------------------------------------------------------------------
  // address decode result
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    K_NONE,
    K_FLAG,
    K_ENABLE,
    K_PRIO,
    K_EVT_STAT,
    K_EVT_MASK
  } irqc_kind_t;

  typedef struct packed {
    irqc_kind_t kind;
    logic [5:0] idx;
  } irqc_dec_t;

endpackage : irqc_pkg

`default_nettype wire

// ### irqc_src_if.sv
// per-source signals between the register file and the request gate
`default_nettype none

interface irqc_src_if #(
  parameter int N  = 64,
  parameter int NP = 16
);
  logic [N-1:0]        pend;
  logic [N-1:0]        en;
  logic [NP-1:0][31:0] pri;
  logic [N-1:0]        active;
  logic [N-1:0][2:0]   level;
  logic [N-1:0][1:0]   sub;

  modport regs (output pend, output en, output pri,
                input active, input level, input sub);
  modport gate (input pend, input en, input pri,
                output active, output level, output sub);
endinterface : irqc_src_if

`default_nettype wire

// ### irqc_gate.sv
// slot field decode and per-source request gating
`default_nettype none

module irqc_gate
  import irqc_pkg::*;
#(
  parameter int N = 64
) (
  // source signals
  irqc_src_if.gate g
);

  for (genvar k = 0; k < N; k++) begin : g_src
    // byte slot of this source inside its priority register
    localparam int REG  = k / SLOTS_PER_REG;
    localparam int BASE = (k % SLOTS_PER_REG) * SLOT_W;

    assign g.level[k] = g.pri[REG][BASE+PRIO_LSB +: PRIO_W];
    assign g.sub[k]   = g.pri[REG][BASE+SUB_LSB +: SUB_W];
    assign g.active[k] = g.pend[k] & g.en[k] & (g.level[k] != PRIO_OFF);
  end

endmodule : irqc_gate

`default_nettype wire

// ### irqc_regs.sv
// interrupt flag, enable and priority registers behind an apb slave
//
// How it works
// - flag sets when its source requests
// - flags are 32-bit software read/write
// - enable bits: one enables, zero disables
// - priority 000 disables, 1 to 7 levels
// - subpriority 0 to 3 from value
// - four byte slots, top three bits zero
`default_nettype none

module irqc_regs
  import irqc_pkg::*;
#(
  parameter int NB = DEF_BANKS
) (
  // clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      pce,
  // apb slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [ADDR_W-1:0]         paddr,
  input  wire logic [DATA_W-1:0]         pwdata,
  output logic      [DATA_W-1:0]         prdata,
  output logic                           pready,
  output logic                           pslverr,
  // peripheral requests
  input  wire logic [NB*SRC_PER_BANK-1:0] src_req,
  // core side
  output logic      [NB*SRC_PER_BANK-1:0] req_active,
  output logic      [NB*SRC_PER_BANK*PRIO_W-1:0] req_level,
  output logic      [NB*SRC_PER_BANK*SUB_W-1:0]  req_sub,
  output logic                           irq
);

  localparam int N  = NB * SRC_PER_BANK;
  localparam int NP = N / SLOTS_PER_REG;

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [NB-1:0][31:0] flag;
    logic [NB-1:0][31:0] en;
    logic [NP-1:0][31:0] pri;
    logic [NB-1:0]       evt_stat;
    logic [NB-1:0]       evt_mask;
    logic [N-1:0]        active;
    logic [31:0]         rdata;
    logic                err;
  } irqc_state_t;

  irqc_state_t s;
  irqc_state_t next_s;
  irqc_dec_t   dec;
  logic        wr_acc;
  logic        rd_setup;
  logic [NB-1:0] evt;

  irqc_src_if #(.N(N), .NP(NP)) src ();

  // ------------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------------
  function automatic irqc_dec_t decode(input logic [ADDR_W-1:0] a);
    irqc_dec_t d;
    logic      in_banks;
    logic      in_prio;
    d.kind   = K_NONE;
    d.idx    = a[7:2];
    in_banks = ({26'h0, a[7:2]} < NB);
    in_prio  = ({26'h0, a[7:2]} < NP);
    if (a[1:0] != 2'h0) begin
      d.kind = K_NONE;
    end else if (a[11:8] == FLAG_REGION && in_banks) begin
      d.kind = K_FLAG;
    end else if (a[11:8] == ENABLE_REGION && in_banks) begin
      d.kind = K_ENABLE;
    end else if (a[11:8] == PRIO_REGION && in_prio) begin
      d.kind = K_PRIO;
    end else if (a[11:8] == EVT_REGION && a[7:2] == EVT_STAT_IDX) begin
      d.kind = K_EVT_STAT;
    end else if (a[11:8] == EVT_REGION && a[7:2] == EVT_MASK_IDX) begin
      d.kind = K_EVT_MASK;
    end
    return d;
  endfunction : decode

  assign dec      = decode(paddr);
  assign wr_acc   = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;

  // ------------------------------------------------------------------
  // request gate
  // ------------------------------------------------------------------
  assign src.pend = s.flag;
  assign src.en   = s.en;
  assign src.pri  = s.pri;

  irqc_gate #(.N(N)) u_gate (
    .g (src.gate)
  );

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    next_s = s;
    evt    = '0;
    for (int b = 0; b < NB; b++) begin
      // software writes the whole flag word
      if (wr_acc && dec.kind == K_FLAG && dec.idx == 6'(b)) begin
        next_s.flag[b] = pwdata;
      end
      // request sets flag, wins over clear
      next_s.flag[b] = next_s.flag[b] | src_req[b*SRC_PER_BANK +: SRC_PER_BANK];
      if (wr_acc && dec.kind == K_ENABLE && dec.idx == 6'(b)) begin
        next_s.en[b] = pwdata;
      end
      // newly active source in this bank
      evt[b] = |(src.active[b*SRC_PER_BANK +: SRC_PER_BANK]
                 & ~s.active[b*SRC_PER_BANK +: SRC_PER_BANK]);
    end
    for (int p = 0; p < NP; p++) begin
      if (wr_acc && dec.kind == K_PRIO && dec.idx == 6'(p)) begin
        next_s.pri[p] = pwdata & PRIO_IMPL_MASK;
      end
    end
    // event status: write one clears, new event wins
    if (wr_acc && dec.kind == K_EVT_STAT) begin
      next_s.evt_stat = s.evt_stat & ~pwdata[NB-1:0];
    end
    next_s.evt_stat = next_s.evt_stat | evt;
    if (wr_acc && dec.kind == K_EVT_MASK) begin
      next_s.evt_mask = pwdata[NB-1:0];
    end
    next_s.active = src.active;
    // read data captured in the setup cycle
    if (rd_setup) begin
      next_s.err   = (dec.kind == K_NONE);
      next_s.rdata = RESET_WORD;
      if (dec.kind == K_FLAG) begin
        next_s.rdata = s.flag[dec.idx];
      end else if (dec.kind == K_ENABLE) begin
        next_s.rdata = s.en[dec.idx];
      end else if (dec.kind == K_PRIO) begin
        next_s.rdata = s.pri[dec.idx];
      end else if (dec.kind == K_EVT_STAT) begin
        next_s.rdata = 32'(s.evt_stat);
      end else if (dec.kind == K_EVT_MASK) begin
        next_s.rdata = 32'(s.evt_mask);
      end
    end
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else if (pce) begin
      s <= next_s;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign prdata     = s.rdata;
  assign pready     = pce;
  assign pslverr    = psel & penable & s.err;
  assign req_active = s.active;
  assign req_level  = src.level;
  assign req_sub    = src.sub;
  assign irq        = |(s.evt_stat & s.evt_mask);

endmodule : irqc_regs

`default_nettype wire

// ### irqc_asserts.sv
// checker for the interrupt register block
`default_nettype none
module irqc_asserts
  import irqc_pkg::*;
#(
  parameter int NB = DEF_BANKS
) (
  // apb side
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              pce,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // source and core side
  input wire logic [NB*32-1:0]  src_req,
  input wire logic [NB*32-1:0]  req_active,
  input wire logic [NB*96-1:0]  req_level,
  input wire logic [NB*64-1:0]  req_sub,
  input wire logic              irq
);
  logic [NB*32-1:0] nz;
  logic             wr;
  logic             cause;
  always_comb begin
    for (int k = 0; k < NB*32; k++) begin
      nz[k] = req_level[3*k +: 3] != 3'h0;
    end
  end
  assign wr = psel && penable && pwrite && pce;
  assign cause = (|src_req) || wr;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_ce: assert property (pready == pce)
    else $error("pready differs from pce");
  a_pad_zero: assert property (psel && penable && !pwrite && paddr[11:8] == PRIO_REGION
    |-> (prdata & ~PRIO_IMPL_MASK) == 32'h0) else $error("slot pad bits set");
  a_active_prio: assert property ((req_active & ~$past(nz)) == '0)
    else $error("active with zero priority");
  a_fields_hold: assert property (!wr |=> $stable(req_sub) && $stable(req_level))
    else $error("slot fields moved");
  a_active_cause: assert property (|(req_active & ~$past(req_active))
    |-> $past(cause, 2)) else $error("active without cause");
  a_active_drop: assert property (|($past(req_active) & ~req_active)
    |-> $past(wr, 2)) else $error("active dropped alone");
  a_irq_hold: assert property (irq && !wr |=> irq)
    else $error("irq dropped alone");
endmodule : irqc_asserts

bind irqc_regs irqc_asserts #(.NB(NB)) i_chk (.pclk(pclk), .presetn(presetn), .pce(pce),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_req(src_req),
  .req_active(req_active), .req_level(req_level), .req_sub(req_sub), .irq(irq));
`default_nettype wire

// ### irqc_periph_model.sv
// peripheral side model that raises source requests
`default_nettype none
module irqc_periph_model (
  // clock and requests
  input  wire logic        pclk,
  output var  logic [63:0] src_req
);
  timeunit 1ns;
  timeprecision 1ns;
  initial src_req = '0;
  task automatic pulse(input int k);
    int w;
    w = $urandom_range(1, 3);
    @(posedge pclk);
    src_req <= 64'h1 << k;
    repeat (w) @(posedge pclk);
    src_req <= '0;
  endtask : pulse
endmodule : irqc_periph_model
`default_nettype wire

// ### tb.sv
// self-checking bench for the interrupt register block
`default_nettype none
module tb
  import irqc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0]  paddr = '0;
  logic [31:0]  pwdata = '0, prdata, rd, exp;
  logic         pready, pslverr, irq, err, m;
  logic [63:0]  src_req, act;
  logic [191:0] lvl;
  logic [127:0] sub;
  logic [2:0]   p;
  logic [1:0]   s;
  int           num_errors = 0, n_compared = 0, k;
  initial forever #50 pclk = ~pclk;
  irqc_periph_model i_per (.pclk(pclk), .src_req(src_req));
  irqc_regs i_dut (.pclk(pclk), .presetn(presetn), .pce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_req(src_req), .req_active(act),
    .req_level(lvl), .req_sub(sub), .irq(irq));
  function automatic logic [11:0] adr(input int i);
    return i < 2 ? 12'(4*i) : i < 4 ? 12'(248 + 4*i) : 12'(496 + 4*i);
  endfunction : adr
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] v);
    n_compared++;
    if (v !== e) begin
      num_errors++;
      $display("unexpected %s exp %h got %h", n, e, v);
    end
  endtask : chk
  task automatic final_report();
    $display("compared %0d mismatched %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  initial begin
    void'($urandom(32'h47538bb9));
    repeat (20) @(posedge pclk);
    presetn <= 1;
    for (k = 0; k < 20; k++) begin
      exp = $urandom;
      apb(0, adr(k), 0);
      chk("reset", 0, rd);
      apb(1, adr(k), exp);
      apb(0, adr(k), 0);
      chk("word", k < 4 ? exp : exp & PRIO_IMPL_MASK, rd);
    end
    apb(0, 12'h400, 0);
    chk("unmapped", 0, rd);
    chk("slverr", 1, {31'h0, err});
    $display("register test done");
    for (k = 0; k < 4; k++) apb(1, adr(k), k < 2 ? 0 : 32'hffffffff);
    for (int j = 0; j < 16; j++) begin
      k = $urandom_range(63);
      p = j == 0 ? 3'h0 : 3'($urandom);
      s = 2'($urandom);
      m = 1'($urandom);
      apb(1, 12'h304, m ? 32'h3 : 32'h0);
      apb(1, 12'h300, 32'h3);
      apb(1, adr(4 + k/4), {3'h0, p, s} << 8*(k%4));
      i_per.pulse(k);
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      chk("active", {31'h0, p != 0}, {31'h0, act[k]});
      chk("level", {29'h0, p}, {29'h0, lvl[3*k +: 3]});
      chk("sub", {30'h0, s}, {30'h0, sub[2*k +: 2]});
      chk("irq", {31'h0, m && p != 0}, {31'h0, irq});
      apb(0, adr(k/32), 0);
      chk("flag", 32'h1 << (k%32), rd);
      apb(1, adr(k/32), 0);
      apb(1, 12'h300, 32'h3);
      @(negedge pclk);
      chk("cleared", 0, {31'h0, irq});
    end
    $display("source test done");
    final_report();
  end
endmodule : tb
`default_nettype wire
